/* File: core/csp_regs.svh */
/*
 * Register offsets, field positions, reset values and timing counts of the
 * serial port, timer and missed frame counter register bank.
 * Assumes inclusion by bare name from the register bank and the testbench.
 */
`ifndef CSP_REGS_SVH
`define CSP_REGS_SVH

`define CSP_OFS_IRQ_ENABLE 8'h38
`define CSP_OFS_SERIAL 8'h48
`define CSP_OFS_TIMER 8'h58
`define CSP_OFS_MISSED 8'h40
`define CSP_OFS_IRQ_STATUS 8'h28

`define CSP_SERIAL_RESET 32'h0004000E
`define CSP_SERIAL_WMASK 32'h00076807
`define CSP_TIMER_RESET 32'h00000000
`define CSP_IRQEN_WMASK 32'h0001AB6F

`define CSP_BIT_MGMT_READ 19
`define CSP_BIT_MGMT_DIR 18
`define CSP_BIT_MGMT_WRITE 17
`define CSP_BIT_MGMT_CLK 16
`define CSP_BIT_EE_READ 14
`define CSP_BIT_EE_WRITE 13
`define CSP_BIT_EE_SELECT 11
`define CSP_BIT_EE_OUT 3
`define CSP_BIT_EE_IN 2
`define CSP_BIT_EE_CLK 1
`define CSP_BIT_EE_CS 0
`define CSP_BIT_CONT 16
`define CSP_BIT_OVFL 16
`define CSP_BIT_TIMER_IE 11
`define CSP_BIT_ABN_IE 15
`define CSP_BIT_TIMER_ST 11

`define CSP_CLK_HZ 20000000
`define CSP_TICK_US 204
`define CSP_TICK_CYCLES ((`CSP_CLK_HZ / 1000000) * `CSP_TICK_US)

`endif

/* File: core/csp_pkg.sv */
/*
 * Types for the serial port, timer and missed frame counter register bank.
 * Assumes the constants header is on the include path.
 */
package csp_pkg;
    typedef enum logic [2:0] {
        CSP_IDLE = 3'b001,
        CSP_WAIT = 3'b010,
        CSP_DONE = 3'b100
    } csp_bus_e;
    typedef logic [31:0] csp_word_t;
endpackage

/* File: core/csp_regs_bank.sv */
/*
 * Register bank with missed frame counter, bit-banged serial port for the
 * PHY management lines and an EEPROM, and a general-purpose countdown timer.
 * Assumes an Avalon-MM master on clk; pins from outside are asynchronous.
 */
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ns
`include "csp_regs.svh"

module csp_regs_bank
    import csp_pkg::*;
#(
    parameter int TICK_CYCLES = `CSP_TICK_CYCLES
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Avalon-MM slave.
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Receive side event.
    input wire logic frameDiscard,
    // PHY management pins.
    output logic mgmtClk,
    input wire logic mgmtDataIn,
    output logic mgmtDataOut,
    output logic mgmtDataOe,
    // EEPROM pins.
    output logic eepromChipSelect,
    output logic eepromClk,
    output logic eepromInBit,
    input wire logic eepromOutBit,
    // Interrupt.
    output logic irq
);
    csp_bus_e busState_q;
    logic [31:0] serial_q, timerCfg_q, irqEn_q, readdata_q;
    logic [15:0] missedCount_q, timerCount_q;
    logic missedOvfl_q, timerRun_q, timerStatus_q, irq_q;
    logic [1:0] mdiSync_q, sdoSync_q;
    logic [31:0] tickCount_q;
    logic tick, timerExpire, busWrite, missedTake, eeAccess;
    logic [31:0] wmaskBe, readValue;

    assign wmaskBe = {{8{byteenable[3]}}, {8{byteenable[2]}},
                      {8{byteenable[1]}}, {8{byteenable[0]}}};

    // Every request waits one cycle, then completes in the DONE state.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busState_q <= CSP_IDLE;
        end else begin
            case (busState_q)
                CSP_IDLE: begin
                    if (read || write) begin
                        busState_q <= CSP_DONE;
                    end
                end
                CSP_WAIT: busState_q <= CSP_DONE;
                CSP_DONE: busState_q <= CSP_IDLE;
                default: busState_q <= CSP_IDLE;
            endcase
        end
    end

    assign busWrite = write && (busState_q == CSP_DONE);
    // A missed counter read clears at the edge that captures its data,
    // so no discard can fall between the snapshot and the clear.
    assign missedTake = read && (busState_q == CSP_IDLE) &&
        (address == `CSP_OFS_MISSED);
    assign waitrequest = !(busState_q == CSP_DONE);

    // Synchronise the two pin inputs before anything reads them.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mdiSync_q <= 2'h0;
            sdoSync_q <= 2'h3;
        end else begin
            mdiSync_q <= {mdiSync_q[0], mgmtDataIn};
            sdoSync_q <= {sdoSync_q[0], eepromOutBit};
        end
    end

    // Missed frame counter; a read clears it, but a coincident discard
    // still counts as one.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            missedCount_q <= 16'h0000;
            missedOvfl_q <= 1'b0;
        end else begin
            if (missedTake) begin
                missedCount_q <= frameDiscard ? 16'h0001 : 16'h0000;
                missedOvfl_q <= frameDiscard &&
                    (missedCount_q == 16'hFFFF);
            end else if (frameDiscard) begin
                missedCount_q <= missedCount_q + 16'h0001;
                if (missedCount_q == 16'hFFFF) begin
                    missedOvfl_q <= 1'b1;
                end
            end
        end
    end

    // Serial port register; read-only bits come from the pins.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            serial_q <= `CSP_SERIAL_RESET;
        end else if (busWrite && address == `CSP_OFS_SERIAL) begin
            serial_q <= (serial_q & ~(`CSP_SERIAL_WMASK & wmaskBe)) |
                        (writedata & `CSP_SERIAL_WMASK & wmaskBe);
        end
    end

    assign eeAccess = serial_q[`CSP_BIT_EE_SELECT] &&
        (serial_q[`CSP_BIT_EE_READ] || serial_q[`CSP_BIT_EE_WRITE]);

    // Pin drivers, each straight from a flip-flop.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mgmtClk <= 1'b0;
            mgmtDataOut <= 1'b0;
            mgmtDataOe <= 1'b0;
            eepromChipSelect <= 1'b0;
            eepromClk <= 1'b0;
            eepromInBit <= 1'b0;
        end else begin
            mgmtClk <= serial_q[`CSP_BIT_MGMT_CLK];
            mgmtDataOut <= serial_q[`CSP_BIT_MGMT_WRITE];
            mgmtDataOe <= !serial_q[`CSP_BIT_MGMT_DIR];
            eepromChipSelect <= eeAccess && serial_q[`CSP_BIT_EE_CS];
            eepromClk <= eeAccess && serial_q[`CSP_BIT_EE_CLK];
            eepromInBit <= eeAccess && serial_q[`CSP_BIT_EE_IN];
        end
    end

    // 204 us tick divider, restarted whenever the timer is loaded.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tickCount_q <= 32'h00000000;
        end else if (!timerRun_q || tick ||
                     (busWrite && address == `CSP_OFS_TIMER)) begin
            tickCount_q <= 32'h00000000;
        end else begin
            tickCount_q <= tickCount_q + 32'h00000001;
        end
    end

    assign tick = timerRun_q && (tickCount_q == 32'(TICK_CYCLES - 1));
    assign timerExpire = tick && (timerCount_q == 16'h0001);

    // Countdown timer.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            timerCfg_q <= `CSP_TIMER_RESET;
            timerCount_q <= 16'h0000;
            timerRun_q <= 1'b0;
        end else if (busWrite && address == `CSP_OFS_TIMER) begin
            timerCfg_q <= {15'h0000, writedata[`CSP_BIT_CONT],
                           writedata[15:0]};
            timerCount_q <= writedata[15:0];
            timerRun_q <= (writedata[15:0] != 16'h0000);
        end else if (timerExpire) begin
            if (timerCfg_q[`CSP_BIT_CONT]) begin
                timerCount_q <= timerCfg_q[15:0];
            end else begin
                timerCount_q <= 16'h0000;
                timerRun_q <= 1'b0;
            end
        end else if (tick) begin
            timerCount_q <= timerCount_q - 16'h0001;
        end
    end

    // Interrupt enable register and sticky expiry status.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irqEn_q <= 32'h00000000;
        end else if (busWrite && address == `CSP_OFS_IRQ_ENABLE) begin
            irqEn_q <= writedata & `CSP_IRQEN_WMASK;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            timerStatus_q <= 1'b0;
        end else if (timerExpire) begin
            timerStatus_q <= 1'b1;
        end else if (busWrite && address == `CSP_OFS_IRQ_STATUS &&
                     writedata[`CSP_BIT_TIMER_ST] && byteenable[1]) begin
            timerStatus_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= timerStatus_q && irqEn_q[`CSP_BIT_TIMER_IE] &&
                     irqEn_q[`CSP_BIT_ABN_IE];
        end
    end
    assign irq = irq_q;

    // Read multiplexer; unmapped addresses read as zero.
    always_comb begin
        readValue = 32'h00000000;
        case (address)
            `CSP_OFS_SERIAL: begin
                readValue = serial_q & `CSP_SERIAL_WMASK;
                readValue[`CSP_BIT_MGMT_READ] = mdiSync_q[1];
                readValue[`CSP_BIT_EE_OUT] = sdoSync_q[1];
            end
            `CSP_OFS_TIMER: readValue = {15'h0000,
                timerCfg_q[`CSP_BIT_CONT], timerCount_q};
            `CSP_OFS_MISSED: readValue = {15'h0000, missedOvfl_q,
                missedCount_q};
            `CSP_OFS_IRQ_ENABLE: readValue = irqEn_q;
            `CSP_OFS_IRQ_STATUS: readValue = {20'h00000, timerStatus_q,
                11'h000};
            default: readValue = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            readdata_q <= 32'h00000000;
        end else if (read && busState_q == CSP_IDLE) begin
            readdata_q <= readValue;
        end
    end
    assign readdata = readdata_q;

    a_missed_read_clear: assert property (@(posedge clk) disable iff (!nrst)
        missedTake && !frameDiscard |=>
        missedCount_q == 16'h0000 && !missedOvfl_q)
        else $error("missed count not cleared by read");
    a_ovfl_wrap: assert property (@(posedge clk) disable iff (!nrst)
        frameDiscard && missedCount_q == 16'hFFFF && !missedTake |=>
        missedOvfl_q && missedCount_q == 16'h0000)
        else $error("overflow did not wrap and latch");
    a_ovfl_hold: assert property (@(posedge clk) disable iff (!nrst)
        missedOvfl_q && !missedTake |=> missedOvfl_q)
        else $error("overflow flag dropped without read");
    a_mgmt_clk_follow: assert property (@(posedge clk) disable iff (!nrst)
        ##1 mgmtClk == $past(serial_q[`CSP_BIT_MGMT_CLK]))
        else $error("management clock does not follow bit");
    a_mgmt_dir_oe: assert property (@(posedge clk) disable iff (!nrst)
        serial_q[`CSP_BIT_MGMT_DIR] |=> !mgmtDataOe)
        else $error("management line driven during read");
    a_ee_gate: assert property (@(posedge clk) disable iff (!nrst)
        eepromChipSelect |-> $past(eeAccess))
        else $error("EEPROM selected without access enable");
    a_timer_stop: assert property (@(posedge clk) disable iff (!nrst)
        timerExpire && !timerCfg_q[`CSP_BIT_CONT] && !busWrite |=>
        !timerRun_q && timerStatus_q)
        else $error("one-shot timer did not stop on expiry");
    a_timer_reload: assert property (@(posedge clk) disable iff (!nrst)
        timerExpire && timerCfg_q[`CSP_BIT_CONT] && !busWrite |=>
        timerCount_q == timerCfg_q[15:0] && timerRun_q)
        else $error("continuous timer did not reload");
    a_irq_gate: assert property (@(posedge clk) disable iff (!nrst)
        irq |-> $past(irqEn_q[`CSP_BIT_TIMER_IE] &&
        irqEn_q[`CSP_BIT_ABN_IE]))
        else $error("interrupt without both enables");


    // A completed request always returns to idle, with waitrequest high again.
    a_wait_restore: assert property (@(posedge clk) disable iff (!nrst)
        busState_q == CSP_DONE |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    // A request seen while idle is answered on the next edge.
    a_bus_answer: assert property (@(posedge clk) disable iff (!nrst)
        (read || write) && busState_q == CSP_IDLE |=> !waitrequest)
        else $error("request not answered on next edge");
    // The management data pin carries the written bit.
    a_mgmt_data: assert property (@(posedge clk) disable iff (!nrst)
        ##1 mgmtDataOut == $past(serial_q[`CSP_BIT_MGMT_WRITE]))
        else $error("management data does not follow bit");
    // Write direction keeps the management line driven.
    a_mgmt_drive: assert property (@(posedge clk) disable iff (!nrst)
        !serial_q[`CSP_BIT_MGMT_DIR] |=> mgmtDataOe)
        else $error("management line not driven during write");
    // The EEPROM select pin follows its bit while access is enabled.
    a_ee_select: assert property (@(posedge clk) disable iff (!nrst)
        ##1 eepromChipSelect ==
        $past(eeAccess && serial_q[`CSP_BIT_EE_CS]))
        else $error("EEPROM select does not follow bit");
    // The EEPROM clock pin follows its bit while access is enabled.
    a_ee_clock: assert property (@(posedge clk) disable iff (!nrst)
        ##1 eepromClk == $past(eeAccess && serial_q[`CSP_BIT_EE_CLK]))
        else $error("EEPROM clock does not follow bit");
    // The EEPROM data pin follows its bit while access is enabled.
    a_ee_data: assert property (@(posedge clk) disable iff (!nrst)
        ##1 eepromInBit == $past(eeAccess && serial_q[`CSP_BIT_EE_IN]))
        else $error("EEPROM data does not follow bit");
    // Without access enable the EEPROM clock and data stay low.
    a_ee_quiet: assert property (@(posedge clk) disable iff (!nrst)
        !eeAccess |=> !eepromClk && !eepromInBit)
        else $error("EEPROM lines move without access enable");
    // A serial port read returns the synchronised management pin.
    a_mgmt_readback: assert property (@(posedge clk) disable iff (!nrst)
        read && busState_q == CSP_IDLE && address == `CSP_OFS_SERIAL |=>
        readdata[`CSP_BIT_MGMT_READ] == $past(mdiSync_q[1]))
        else $error("management read bit not returned");
    // A serial port read returns the synchronised EEPROM pin.
    a_ee_readback: assert property (@(posedge clk) disable iff (!nrst)
        read && busState_q == CSP_IDLE && address == `CSP_OFS_SERIAL |=>
        readdata[`CSP_BIT_EE_OUT] == $past(sdoSync_q[1]))
        else $error("EEPROM out bit not returned");
    // Each discard outside a read adds exactly one.
    a_missed_step: assert property (@(posedge clk) disable iff (!nrst)
        frameDiscard && !missedTake |=>
        missedCount_q == $past(missedCount_q) + 16'h0001)
        else $error("missed count did not step by one");
    // With neither discard nor read the count holds.
    a_missed_hold: assert property (@(posedge clk) disable iff (!nrst)
        !frameDiscard && !missedTake |=> $stable(missedCount_q))
        else $error("missed count changed without cause");
    // The overflow flag rises only on a wrap.
    a_ovfl_cause: assert property (@(posedge clk) disable iff (!nrst)
        !missedOvfl_q && !(frameDiscard && missedCount_q == 16'hFFFF) |=>
        !missedOvfl_q)
        else $error("overflow flag set without wrap");
    // Bits that software cannot write keep their reset value.
    a_serial_fixed: assert property (@(posedge clk) disable iff (!nrst)
        (serial_q & ~`CSP_SERIAL_WMASK) ==
        (`CSP_SERIAL_RESET & ~`CSP_SERIAL_WMASK))
        else $error("serial port fixed bits changed");
    // A timer write loads the count directly.
    a_timer_load: assert property (@(posedge clk) disable iff (!nrst)
        busWrite && address == `CSP_OFS_TIMER |=>
        timerCount_q == $past(writedata[15:0]))
        else $error("timer count not loaded");
    // A tick short of expiry takes one off the count.
    a_timer_step: assert property (@(posedge clk) disable iff (!nrst)
        tick && !timerExpire && !busWrite |=>
        timerCount_q == $past(timerCount_q) - 16'h0001)
        else $error("timer did not count down by one");
    // Between ticks and loads the count holds.
    a_timer_hold: assert property (@(posedge clk) disable iff (!nrst)
        !tick && !busWrite |=> $stable(timerCount_q))
        else $error("timer count changed between ticks");
    // An expiry always leaves the sticky status set.
    a_status_set: assert property (@(posedge clk) disable iff (!nrst)
        timerExpire |=> timerStatus_q)
        else $error("expiry did not set status");
    // The status stays until software writes the status register.
    a_status_hold: assert property (@(posedge clk) disable iff (!nrst)
        timerStatus_q && !(busWrite && address == `CSP_OFS_IRQ_STATUS) |=>
        timerStatus_q)
        else $error("status dropped without clear");
    // Status with both enables raises the interrupt.
    a_irq_raise: assert property (@(posedge clk) disable iff (!nrst)
        timerStatus_q && irqEn_q[`CSP_BIT_TIMER_IE] &&
        irqEn_q[`CSP_BIT_ABN_IE] |=> irq)
        else $error("interrupt missing with both enables");

    c_expire: cover property (@(posedge clk) disable iff (!nrst)
        timerExpire);
    c_reload: cover property (@(posedge clk) disable iff (!nrst)
        timerExpire && timerCfg_q[`CSP_BIT_CONT]);
    c_missed_clear: cover property (@(posedge clk) disable iff (!nrst)
        missedTake && missedCount_q != 16'h0000);
    c_ovfl: cover property (@(posedge clk) disable iff (!nrst)
        $rose(missedOvfl_q));
    c_irq: cover property (@(posedge clk) disable iff (!nrst) $rose(irq));
endmodule

/* File: tb/csp_far_model.sv */
/*
 * Behavioural model of the PHY management lines and the serial EEPROM.
 * Assumes the register bank drives clocks and data from software bits.
 */
`timescale 1ns/1ns
module csp_far_model (
    // Management lines.
    input wire logic mgmtClk,
    input wire logic mgmtDataOut,
    input wire logic mgmtDataOe,
    output logic mgmtDataIn,
    // EEPROM lines.
    input wire logic eepromChipSelect,
    input wire logic eepromClk,
    input wire logic eepromInBit,
    output logic eepromOutBit
);
    logic [7:0] phyQ = 8'hA5;
    logic [7:0] eeQ = 8'h3C;

    always @(posedge mgmtClk) begin
        phyQ <= {phyQ[6:0], mgmtDataOe ? mgmtDataOut : phyQ[7]};
    end
    // The management line reads high while the bank drives it.
    assign mgmtDataIn = mgmtDataOe ? 1'b1 : phyQ[7];

    always @(posedge eepromClk) begin
        if (eepromChipSelect) begin
            eeQ <= {eeQ[6:0], eepromInBit};
        end
    end
    // A deselected part shows the inverse of its last bit.
    assign eepromOutBit = eepromChipSelect ? eeQ[7] : ~eeQ[7];
endmodule

/* File: tb/tb.sv */
/*
 * Self-checking bench for the serial port, timer and missed frame counter.
 * Assumes the design package and constants header are compiled first.
 */
`timescale 1ns/1ns
`include "csp_regs.svh"
module tb;
    import csp_pkg::*;
    typedef struct {csp_word_t wr; logic [5:0] pins;} csp_row_s;
    logic clk = 0, nrst = 0, read = 0, write = 0, frameDiscard = 0;
    logic [7:0] address = 8'h00;
    logic [3:0] byteenable = 4'hF;
    csp_word_t writedata = 32'h0, readdata, rd;
    logic waitrequest, mgmtClk, mgmtDataIn, mgmtDataOut, mgmtDataOe, irq;
    logic eepromChipSelect, eepromClk, eepromInBit, eepromOutBit;
    int failCount = 0, testsRun = 0, n;
    csp_row_s rows[8];

    always #25 clk = ~clk;

    csp_regs_bank #(.TICK_CYCLES(4)) u_dut (.clk(clk), .nrst(nrst),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .frameDiscard(frameDiscard), .mgmtClk(mgmtClk),
        .mgmtDataIn(mgmtDataIn), .mgmtDataOut(mgmtDataOut),
        .mgmtDataOe(mgmtDataOe), .eepromChipSelect(eepromChipSelect),
        .eepromClk(eepromClk), .eepromInBit(eepromInBit),
        .eepromOutBit(eepromOutBit), .irq(irq));
    csp_far_model u_far (.mgmtClk(mgmtClk), .mgmtDataOut(mgmtDataOut),
        .mgmtDataOe(mgmtDataOe), .mgmtDataIn(mgmtDataIn),
        .eepromChipSelect(eepromChipSelect), .eepromClk(eepromClk),
        .eepromInBit(eepromInBit), .eepromOutBit(eepromOutBit));

    task wrapUp;
        $display("checks %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task check(input string what, input csp_word_t seen, input csp_word_t exp);
        testsRun++;
        if (seen !== exp) begin
            failCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One Avalon-MM transfer; read data land in rd.
    task bus(input logic wr, input logic [7:0] a, input csp_word_t d);
        int k;
        k = 0;
        @(posedge clk);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= d;
        do begin
            @(posedge clk);
            k++;
        end while (waitrequest !== 1'b0 && k < 50);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (k >= 50) begin
            failCount++;
            wrapUp;
        end
    endtask

    task waitIrq(input logic lvl);
        n = 0;
        while (irq !== lvl && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n >= 200) begin
            failCount++;
            wrapUp;
        end
    endtask

    initial begin
        repeat (90000) @(posedge clk);
        failCount++;
        wrapUp;
    end

    initial begin
        rows[0] = '{32'h00070000, 6'b011000};
        rows[1] = '{32'h00020000, 6'b110000};
        rows[2] = '{32'h00004807, 6'b100111};
        rows[3] = '{32'h00002807, 6'b100111};
        rows[4] = '{32'h00000807, 6'b100000};
        rows[5] = '{32'h00004007, 6'b100000};
        rows[6] = '{32'h00004803, 6'b100110};
        rows[7] = '{32'h00010000, 6'b101000};
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        bus(1'b0, `CSP_OFS_SERIAL, 32'h0);
        check("serial reset", rd & 32'h0007680F, `CSP_SERIAL_RESET);
        bus(1'b0, `CSP_OFS_TIMER, 32'h0);
        check("timer reset", rd, `CSP_TIMER_RESET);
        foreach (rows[i]) begin
            bus(1'b1, `CSP_OFS_SERIAL, rows[i].wr);
            repeat (2) @(negedge clk);
            check("pins", csp_word_t'({mgmtDataOe, mgmtDataOut, mgmtClk,
                eepromChipSelect, eepromClk, eepromInBit}),
                csp_word_t'(rows[i].pins));
            bus(1'b0, `CSP_OFS_SERIAL, 32'h0);
            check("serial bits", rd & `CSP_SERIAL_WMASK,
                rows[i].wr & `CSP_SERIAL_WMASK);
        end
        // Pin images through the synchronisers, with the pins changing.
        for (int j = 0; j < 3; j++) begin
            bus(1'b1, `CSP_OFS_SERIAL, 32'h00040000 | (j * 32'h00014803));
            repeat (4) @(posedge clk);
            bus(1'b0, `CSP_OFS_SERIAL, 32'h0);
            check("mgmt read bit", 32'(rd[19]), 32'(mgmtDataIn));
            check("eeprom out bit", 32'(rd[3]), 32'(eepromOutBit));
        end
        @(posedge clk) frameDiscard <= 1'b1;
        repeat (3) @(posedge clk);
        frameDiscard <= 1'b0;
        bus(1'b0, `CSP_OFS_MISSED, 32'h0);
        check("missed count", rd, 32'h00000003);
        bus(1'b0, `CSP_OFS_MISSED, 32'h0);
        check("missed cleared", rd, 32'h00000000);
        @(posedge clk) frameDiscard <= 1'b1;
        repeat (65538) @(posedge clk);
        frameDiscard <= 1'b0;
        bus(1'b0, `CSP_OFS_MISSED, 32'h0);
        check("missed overflow", rd, 32'h00010002);
        bus(1'b0, `CSP_OFS_MISSED, 32'h0);
        check("overflow cleared", rd, 32'h00000000);
        bus(1'b1, `CSP_OFS_IRQ_ENABLE, 32'h00008800);
        bus(1'b1, `CSP_OFS_TIMER, 32'h00000003);
        waitIrq(1'b1);
        check("tick spacing", 32'(n >= 9 && n <= 15), 32'h1);
        bus(1'b0, `CSP_OFS_IRQ_STATUS, 32'h0);
        check("expiry status", 32'(rd[11]), 32'h1);
        bus(1'b1, `CSP_OFS_IRQ_STATUS, 32'h00000800);
        repeat (20) @(negedge clk);
        check("one-shot stays quiet", 32'(irq), 32'h0);
        bus(1'b0, `CSP_OFS_TIMER, 32'h0);
        check("one-shot stopped", rd, 32'h00000000);
        bus(1'b1, `CSP_OFS_IRQ_ENABLE, 32'h00000800);
        bus(1'b1, `CSP_OFS_TIMER, 32'h00000002);
        repeat (20) @(negedge clk);
        check("summary off", 32'(irq), 32'h0);
        bus(1'b1, `CSP_OFS_IRQ_ENABLE, 32'h00008000);
        repeat (2) @(negedge clk);
        check("timer enable off", 32'(irq), 32'h0);
        bus(1'b1, `CSP_OFS_IRQ_ENABLE, 32'h00008800);
        repeat (2) @(negedge clk);
        check("both enables", 32'(irq), 32'h1);
        bus(1'b1, `CSP_OFS_IRQ_STATUS, 32'h00000800);
        bus(1'b1, `CSP_OFS_TIMER, 32'h00010002);
        waitIrq(1'b1);
        bus(1'b1, `CSP_OFS_IRQ_STATUS, 32'h00000800);
        waitIrq(1'b0);
        waitIrq(1'b1);
        check("continuous reload", 32'(n <= 12), 32'h1);
        bus(1'b1, `CSP_OFS_TIMER, 32'h0);
        wrapUp;
    end
endmodule
